// ==== design/pcl_ctrl.sv ====
// Register slave and control logic for PHY basic control low fields
module pcl_ctrl #(
  parameter int unsigned DATA_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  input wire logic autoneg_set_full,
  input wire logic autoneg_restart_ack,
  input wire logic tx_start,
  input wire logic tx_halt,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_en,
  input wire logic [DATA_W-1:0] rx_data,
  input wire logic rx_dv,
  output logic [DATA_W-1:0] tx_data_q,
  output logic tx_en_q,
  output logic [DATA_W-1:0] rx_data_q,
  output logic rx_dv_q,
  output logic phy_low_power_q,
  output logic isolate_q,
  output logic autoneg_restart_q,
  output logic full_duplex_q,
  output logic collision_test_enable_q
);
  //////////////////////////////////////////////////////////////////////////////
  // Decode
  logic ctrl_wr;
  logic ctrl_rd;
  logic stat_rd;
  logic [6:0] rsvd_q;
  logic tx_active_q;

  // Address match for one register offset
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] offset);
    return addr == offset;
  endfunction : addr_hit

  assign ctrl_wr = reg_wr && addr_hit(reg_addr, pcl_pkg::PCL_CTRL_OFFSET);
  assign ctrl_rd = reg_rd && addr_hit(reg_addr, pcl_pkg::PCL_CTRL_OFFSET);
  assign stat_rd = reg_rd && addr_hit(reg_addr, pcl_pkg::PCL_STAT_OFFSET);

  //////////////////////////////////////////////////////////////////////////////
  // Control bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phy_low_power_q <= pcl_pkg::PCL_LOW_POWER_RST;
      isolate_q <= pcl_pkg::PCL_ISOLATE_RST;
      rsvd_q <= pcl_pkg::PCL_RSVD_RST;
    end else if (ctrl_wr) begin
      phy_low_power_q <= reg_wdata[pcl_pkg::PCL_LOW_POWER_BIT]; // [R01]
      isolate_q <= reg_wdata[pcl_pkg::PCL_ISOLATE_BIT]; // [R02]
      rsvd_q <= reg_wdata[6:0]; // [R07]
    end
  end

  // Duplex: software write, negotiation may set; set wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_duplex_q <= pcl_pkg::PCL_DUPLEX_RST;
    end else if (autoneg_set_full) begin
      full_duplex_q <= 1'h1; // [R04]
    end else if (ctrl_wr) begin
      full_duplex_q <= reg_wdata[pcl_pkg::PCL_DUPLEX_BIT]; // [R03] [R04]
    end
  end

  // Restart: set by write of one, cleared once restart begun
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      autoneg_restart_q <= pcl_pkg::PCL_RESTART_RST;
    end else if (ctrl_wr && reg_wdata[pcl_pkg::PCL_RESTART_BIT]) begin
      autoneg_restart_q <= 1'h1; // [R09]
    end else if (autoneg_restart_ack) begin
      autoneg_restart_q <= 1'h0; // [R09]
    end
  end

  // Collision test: software set, or transmission start; cleared on halt, or by a write with bit 7 clear while no transmission is active
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      collision_test_enable_q <= pcl_pkg::PCL_COLLISION_TEST_ENABLE_RST;
      tx_active_q <= 1'h0;
    end else begin
      if (tx_start) begin
        tx_active_q <= 1'h1;
      end else if (tx_halt) begin
        tx_active_q <= 1'h0;
      end
      if (ctrl_wr && reg_wdata[pcl_pkg::PCL_COLLISION_TEST_ENABLE_BIT]) begin
        collision_test_enable_q <= 1'h1; // [R05]
      end else if (tx_start) begin
        collision_test_enable_q <= 1'h1; // [R06]
      end else if (tx_halt || (ctrl_wr && !tx_active_q)) begin
        collision_test_enable_q <= 1'h0; // [R06]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (ctrl_rd) begin
        reg_rdata_q <= pcl_pkg::PCL_UPPER_RST | {4'h0, phy_low_power_q, isolate_q,
                       autoneg_restart_q, full_duplex_q, collision_test_enable_q,
                       rsvd_q}; // [R08]
      end else if (stat_rd) begin
        reg_rdata_q <= {15'h0, tx_active_q};
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data path
  pcl_gate #(.WIDTH(DATA_W)) u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .low_power(phy_low_power_q),
    .isolate(isolate_q),
    .tx_in(tx_data),
    .tx_en_in(tx_en),
    .rx_in(rx_data),
    .rx_dv_in(rx_dv),
    .tx_out_q(tx_data_q),
    .tx_en_out_q(tx_en_q),
    .rx_out_q(rx_data_q),
    .rx_dv_out_q(rx_dv_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_tx_start;
    tx_start;
  endsequence

  sequence s_tx_halt;
    tx_halt && !tx_start;
  endsequence

  sequence s_ctrl_read;
    ctrl_rd;
  endsequence

  sequence s_stat_read;
    stat_rd;
  endsequence

  chk_lowpower_ignore : assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    phy_low_power_q |=> !rx_dv_q)
    else $error("Receive data passed in low power");
  chk_lowpower_tx : assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    phy_low_power_q |=> !tx_en_q && tx_data_q == '0)
    else $error("Transmit data passed in low power");
  chk_lowpower_write : assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    ctrl_wr |=> phy_low_power_q == $past(reg_wdata[11]))
    else $error("Low power bit did not follow write");
  chk_tx_pass : assert property (@(posedge ref_clk) disable iff (rst) // [R01]
    !phy_low_power_q && !isolate_q && !$past(rst) |=> tx_en_q == $past(tx_en)
      && tx_data_q == $past(tx_data))
    else $error("Transmit data not passed when open");
  chk_rx_pass : assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    !phy_low_power_q && !isolate_q && !$past(rst) |=> rx_dv_q == $past(rx_dv)
      && rx_data_q == $past(rx_data))
    else $error("Receive data not passed when open");
  chk_isolate_write : assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    ctrl_wr |=> isolate_q == $past(reg_wdata[10]))
    else $error("Isolate not applied");
  chk_isolate_gates : assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    isolate_q |=> !tx_en_q && !rx_dv_q)
    else $error("Data passed while isolated");
  chk_isolate_hold : assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    !ctrl_wr |=> $stable(isolate_q) && $stable(phy_low_power_q))
    else $error("Isolate or low power changed without write");
  chk_duplex_write : assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    ctrl_wr && !autoneg_set_full |=> full_duplex_q == $past(reg_wdata[8]))
    else $error("Duplex bit did not follow write");
  chk_duplex_hold : assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    !ctrl_wr && !autoneg_set_full |=> $stable(full_duplex_q))
    else $error("Duplex bit changed without cause");
  chk_duplex_autoneg : assert property (@(posedge ref_clk) disable iff (rst) // [R04]
    autoneg_set_full |=> full_duplex_q)
    else $error("Negotiation failed to set duplex");
  chk_collision_test_enable_write : assert property (@(posedge ref_clk) disable iff (rst) // [R05]
    ctrl_wr && reg_wdata[7] |=> collision_test_enable_q)
    else $error("Collision test not enabled");
  chk_collision_test_enable_write_clear : assert property (@(posedge ref_clk) disable iff (rst) // [R05]
    ctrl_wr && !reg_wdata[7] && !tx_active_q && !tx_start |=> !collision_test_enable_q)
    else $error("Collision test not disabled by write");
  chk_collision_test_enable_tx_start : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    s_tx_start |=> collision_test_enable_q)
    else $error("Collision test not set at transmit start");
  chk_collision_test_enable_halt : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    tx_halt && !tx_start && !(ctrl_wr && reg_wdata[7]) |=> !collision_test_enable_q)
    else $error("Collision test not cleared at halt");
  chk_collision_test_enable_hold : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    !ctrl_wr && !tx_start && !tx_halt |=> $stable(collision_test_enable_q))
    else $error("Collision test changed without cause");
  chk_tx_active : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    s_tx_start |=> tx_active_q)
    else $error("Transmission not marked active");
  chk_tx_inactive : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    s_tx_halt |=> !tx_active_q)
    else $error("Transmission not marked halted");
  chk_stat_read : assert property (@(posedge ref_clk) disable iff (rst) // [R06]
    s_stat_read |=> reg_rdata_q == {15'h0, $past(tx_active_q)})
    else $error("Status read data wrong");
  chk_restart_set : assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    ctrl_wr && reg_wdata[9] |=> autoneg_restart_q)
    else $error("Restart bit not set");
  chk_restart_clear : assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    autoneg_restart_ack && !(ctrl_wr && reg_wdata[9]) |=> !autoneg_restart_q)
    else $error("Restart bit not cleared");
  chk_restart_hold : assert property (@(posedge ref_clk) disable iff (rst) // [R09]
    !(ctrl_wr && reg_wdata[9]) && !autoneg_restart_ack |=> $stable(autoneg_restart_q))
    else $error("Restart bit changed without cause");
  chk_ctrl_readback : assert property (@(posedge ref_clk) disable iff (rst) // [R03]
    s_ctrl_read |=> reg_rdata_q[15:12] == pcl_pkg::PCL_UPPER_RST[15:12]
      && reg_rdata_q[11:0] == $past({phy_low_power_q, isolate_q, autoneg_restart_q,
      full_duplex_q, collision_test_enable_q, rsvd_q}))
    else $error("Control read data wrong");
  chk_rsvd_write : assert property (@(posedge ref_clk) disable iff (rst) // [R07]
    ctrl_wr |=> rsvd_q == $past(reg_wdata[6:0]))
    else $error("Reserved field did not follow write");
endmodule : pcl_ctrl

// ==== design/pcl_gate.sv ====
// Data path gating for low-power and isolate
module pcl_gate #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic low_power,
  input wire logic isolate,
  input wire logic [WIDTH-1:0] tx_in,
  input wire logic tx_en_in,
  input wire logic [WIDTH-1:0] rx_in,
  input wire logic rx_dv_in,
  output logic [WIDTH-1:0] tx_out_q,
  output logic tx_en_out_q,
  output logic [WIDTH-1:0] rx_out_q,
  output logic rx_dv_out_q
);
  logic block_d;
  assign block_d = low_power | isolate; // [R01] [R02]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_out_q <= '0;
      tx_en_out_q <= 1'h0;
      rx_out_q <= '0;
      rx_dv_out_q <= 1'h0;
    end else begin
      tx_out_q <= block_d ? '0 : tx_in; // [R01] [R02]
      tx_en_out_q <= tx_en_in & ~block_d;
      rx_out_q <= block_d ? '0 : rx_in;
      rx_dv_out_q <= rx_dv_in & ~block_d;
    end
  end

  chk_gate_blocks : assert property (@(posedge ref_clk) disable iff (rst) // [R02]
    block_d |=> !tx_en_out_q && !rx_dv_out_q)
    else $error("Data passed while gated");
endmodule : pcl_gate

// ==== design/pcl_pkg.sv ====
// Package with constants for the PHY basic control low fields
// How it works
// [R01] Low-power bit idles PHY, ignores data inputs
// [R02] Isolate bit disconnects transmit and receive paths
// [R03] Duplex bit: one full, zero half duplex
// [R04] Software or negotiation may set duplex
// [R05] Collision test bit enables collision test mode
// [R06] Collision test sets at transmit start, clears after
// [R07] Software writes reserved bits as zero
// [R08] Software preserves reserved bits on read-modify-write
// [R09] Restart bit restarts negotiation, self-clears
package pcl_pkg;
  localparam int unsigned PCL_ADDR_W = 5;
  localparam logic [4:0] PCL_CTRL_OFFSET = 5'h00;
  localparam logic [4:0] PCL_STAT_OFFSET = 5'h1f;
  localparam int unsigned PCL_LOW_POWER_BIT = 11;
  localparam int unsigned PCL_ISOLATE_BIT = 10;
  localparam int unsigned PCL_RESTART_BIT = 9;
  localparam int unsigned PCL_DUPLEX_BIT = 8;
  localparam int unsigned PCL_COLLISION_TEST_ENABLE_BIT = 7;
  localparam logic PCL_LOW_POWER_RST = 1'h0;
  localparam logic PCL_ISOLATE_RST = 1'h0;
  localparam logic PCL_RESTART_RST = 1'h0;
  localparam logic PCL_DUPLEX_RST = 1'h1;
  localparam logic PCL_COLLISION_TEST_ENABLE_RST = 1'h0;
  localparam logic [6:0] PCL_RSVD_RST = 7'h00;
  localparam logic [15:0] PCL_UPPER_RST = 16'h3000;
endpackage : pcl_pkg

// ==== tb/phy_control_low_fields_bench.sv ====
// Self-checking bench for the PHY basic control low fields
module phy_control_low_fields_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  logic autoneg_set_full = 1'b0;
  logic autoneg_restart_ack = 1'b0;
  logic tx_start = 1'b0;
  logic tx_halt = 1'b0;
  logic [3:0] tx_data = 4'ha;
  logic tx_en = 1'b1;
  logic [3:0] rx_data = 4'h5;
  logic rx_dv = 1'b1;
  logic [3:0] tx_data_q;
  logic [3:0] rx_data_q;
  logic tx_en_q, rx_dv_q, phy_low_power_q, isolate_q;
  logic autoneg_restart_q, full_duplex_q, collision_test_enable_q;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  pcl_ctrl #(.DATA_W(4)) u_pcl_ctrl (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .autoneg_set_full(autoneg_set_full), .autoneg_restart_ack(autoneg_restart_ack),
    .tx_start(tx_start), .tx_halt(tx_halt), .tx_data(tx_data), .tx_en(tx_en),
    .rx_data(rx_data), .rx_dv(rx_dv), .tx_data_q(tx_data_q), .tx_en_q(tx_en_q),
    .rx_data_q(rx_data_q), .rx_dv_q(rx_dv_q), .phy_low_power_q(phy_low_power_q),
    .isolate_q(isolate_q), .autoneg_restart_q(autoneg_restart_q),
    .full_duplex_q(full_duplex_q), .collision_test_enable_q(collision_test_enable_q));
  ////////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge ref_clk) reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_q);
  endtask : rd
  task automatic pulse(input int which);
    @(posedge ref_clk) case (which)
      0: autoneg_set_full <= 1'b1;
      1: autoneg_restart_ack <= 1'b1;
      2: tx_start <= 1'b1;
      default: tx_halt <= 1'b1;
    endcase
    @(posedge ref_clk) {autoneg_set_full, autoneg_restart_ack, tx_start, tx_halt} <= 4'h0;
    #1;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(5'h00, 16'h3100);
    rd(5'h05, 16'h0000);
    $display("Test reset and unmapped done");
    wr(5'h00, 16'h0900);
    @(posedge ref_clk) #1;
    chk("low power", 16'h0001, {15'h0, phy_low_power_q});
    chk("tx gated", 16'h0000, {11'h0, tx_en_q, tx_data_q});
    wr(5'h00, 16'h0500);
    @(posedge ref_clk) #1;
    chk("rx gated", 16'h0000, {11'h0, rx_dv_q, rx_data_q});
    chk("isolate", 16'h0001, {15'h0, isolate_q});
    rd(5'h00, 16'h3500);
    wr(5'h00, 16'h0100);
    @(posedge ref_clk) #1;
    chk("tx pass", 16'h001a, {11'h0, tx_en_q, tx_data_q});
    chk("rx pass", 16'h0015, {11'h0, rx_dv_q, rx_data_q});
    $display("Test data gating done");
    wr(5'h00, 16'h0000);
    chk("half duplex", 16'h0000, {15'h0, full_duplex_q});
    pulse(0);
    chk("negotiated full", 16'h0001, {15'h0, full_duplex_q});
    $display("Test duplex done");
    wr(5'h00, 16'h0180);
    chk("collision test on", 16'h0001, {15'h0, collision_test_enable_q});
    wr(5'h00, 16'h0100);
    chk("collision test off", 16'h0000, {15'h0, collision_test_enable_q});
    pulse(2);
    chk("set by transmit", 16'h0001, {15'h0, collision_test_enable_q});
    rd(5'h1f, 16'h0001);
    wr(5'h00, 16'h0100);
    rd(5'h00, 16'h3180);
    pulse(3);
    chk("cleared by halt", 16'h0000, {15'h0, collision_test_enable_q});
    $display("Test collision done");
    wr(5'h00, 16'h0300);
    wr(5'h00, 16'h0300);
    chk("restart set", 16'h0001, {15'h0, autoneg_restart_q});
    pulse(1);
    chk("restart self clear", 16'h0000, {15'h0, autoneg_restart_q});
    rd(5'h00, 16'h3100);
    wr(5'h05, 16'h0c00);
    rd(5'h00, 16'h3100);
    wr(5'h00, 16'h0100);
    rd(5'h00, 16'h3100);
    $display("Test restart done");
    final_report();
  end
endmodule : phy_control_low_fields_bench
